//--- bench/sfsr_host.sv
`timescale 1ns/1ps
module sfsr_host (
  output logic sclk,
  output logic cs_n,
  output logic si_i,
  input wire logic so_o,
  input wire logic so_oe_n
);
  // mode 0, sclk stands low between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si_i = 1'b0;
  end
  task automatic frame(input logic [7:0] op, input int n,
                       output logic [63:0] rx, output logic oe);
    rx = '0;
    oe = 1'b0;
    cs_n = 1'b0;
    #6;
    for (int i = 0; i < 8 + n; i++) begin
      // after the opcode si is unused, so it toggles
      si_i = (i < 8) ? op[7 - i] : ~si_i;
      #6 sclk = 1'b1;
      if (i >= 8) begin
        rx = {rx[62:0], so_o};
        oe = oe | !so_oe_n;
      end
      #6 sclk = 1'b0;
    end
    #3 cs_n = 1'b1;
    si_i = ~si_i;
    #60;
  endtask
endmodule

//--- bench/sfsr_monitor.sv
`timescale 1ns/1ps
module sfsr_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic so_oe_n,
  input wire logic busy_i,
  input wire logic erase_paused_i,
  input wire logic program_paused_i,
  input wire logic latch_set_i,
  input wire logic latch_clr_i,
  input wire logic wrsr_valid_i,
  input wire logic [7:0] status_one_o,
  input wire logic [7:0] status_two_o,
  input wire logic [7:0] status_three_o,
  input wire logic quad_io_enable_o,
  input wire logic [1:0] output_strength_o
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  oe_off_a: assert property (cs_n && $past(cs_n) |-> so_oe_n)
    else $error("serial out driven while idle");
  rst_vals_a: assert property (!$past(rst_n) |->
    status_one_o == 8'h00 && status_two_o == 8'h00 &&
    status_three_o == 8'h60)
    else $error("bad value after reset");
  busy_track_a: assert property ($past(rst_n) |->
    status_one_o[0] == $past(busy_i))
    else $error("busy flag not tracking");
  susp_track_a: assert property ($past(rst_n) |->
    {status_two_o[7], status_two_o[2]} ==
    {$past(erase_paused_i), $past(program_paused_i)})
    else $error("suspend flags not tracking");
  latch_set_a: assert property (latch_set_i |=> status_one_o[1])
    else $error("latch not set");
  latch_clr_a: assert property ((wrsr_valid_i || latch_clr_i) &&
    !latch_set_i |=> !status_one_o[1])
    else $error("latch not cleared");
  write_refuse_a: assert property (wrsr_valid_i &&
    !status_one_o[1] |=> $stable(status_three_o) &&
    $stable(status_one_o[7:2]))
    else $error("write taken without latch");
  lock_keep_a: assert property ($past(rst_n) |->
    ($past(status_two_o[5:3]) & ~status_two_o[5:3]) == 3'h0)
    else $error("lock bit cleared");
  mode_outs_a: assert property (
    {quad_io_enable_o, output_strength_o} ==
    {status_two_o[1], status_three_o[6:5]})
    else $error("mode outputs disagree");
  cov_lock: cover property (status_two_o[3]);
  cov_refuse: cover property (wrsr_valid_i && !status_one_o[1]);
  cov_ready: cover property ($fell(status_one_o[0]));
  cov_read: cover property (!cs_n && !so_oe_n);
endmodule
bind sfsr_status_read sfsr_monitor mon_u (.clk, .rst_n, .cs_n, .so_oe_n,
  .busy_i, .erase_paused_i, .program_paused_i, .latch_set_i, .latch_clr_i,
  .wrsr_valid_i, .status_one_o, .status_two_o, .status_three_o,
  .quad_io_enable_o, .output_strength_o);

//--- bench/tb_flash_status_register_read.sv
`timescale 1ns/1ps
module tb_flash_status_register_read;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic busy_i = 1'b0;
  logic erase_paused_i = 1'b0;
  logic program_paused_i = 1'b0;
  logic latch_set_i = 1'b0;
  logic latch_clr_i = 1'b0;
  logic wrsr_valid_i = 1'b0;
  logic [1:0] wrsr_sel_i = 2'h0;
  logic [7:0] wrsr_data_i = 8'h00;
  logic sclk, cs_n, si_i, so_o, so_oe_n, quad_io_enable_o;
  logic [7:0] status_one_o, status_two_o, status_three_o;
  logic [1:0] output_strength_o;
  logic [7:0] e1 = 8'h00, e2 = 8'h00, e3 = 8'h60;
  logic lat = 1'b0;
  logic [7:0] opc [3] = '{8'h05, 8'h35, 8'h15};
  int n_fail = 0, n_compared = 0, seed = 9;
  always #5 clk = ~clk;
  sfsr_status_read dut_u (.clk, .rst_n, .sclk, .cs_n, .si_i, .wp_n, .so_o,
    .so_oe_n, .busy_i, .erase_paused_i, .program_paused_i, .latch_set_i,
    .latch_clr_i, .wrsr_valid_i, .wrsr_sel_i, .wrsr_data_i, .status_one_o,
    .status_two_o, .status_three_o, .quad_io_enable_o, .output_strength_o);
  sfsr_host h_u (.sclk, .cs_n, .si_i, .so_o, .so_oe_n);
  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] ex(input int s);
    case (s)
      0: ex = {e1[7:2], lat, busy_i};
      1: ex = {erase_paused_i, e2[6:3], program_paused_i, e2[1:0]};
      default: ex = e3;
    endcase
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    wrsr_sel_i = s;
    wrsr_data_i = d;
    wrsr_valid_i = 1'b1;
    cyc(1);
    wrsr_valid_i = 1'b0;
    if (lat && !e2[0] && (!e1[7] || wp_n)) begin
      case (s)
        0: e1 = d & 8'hFC;
        1: e2 = (d & 8'h7B) | (e2 & 8'h38);
        2: e3 = d;
        default: ;
      endcase
    end
    lat = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input int s);
    logic [63:0] rx;
    logic oe;
    h_u.frame(opc[s], 16, rx, oe);
    chk(rx[15:8], ex(s));
    chk(rx[7:0], ex(s));
    chk({7'h00, oe}, 8'h01);
    chk({7'h00, so_oe_n}, 8'h01);
  endtask
  task automatic regs();
    chk(status_one_o, ex(0));
    chk(status_two_o, ex(1));
    chk(status_three_o, ex(2));
    chk({5'h00, quad_io_enable_o, output_strength_o},
        {5'h00, e2[1], e3[6:5]});
  endtask
  task automatic results();
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    results();
  end
  initial begin
    logic [63:0] rx;
    logic oe;
    logic [7:0] b;
    int r;
    cyc(6);
    rst_n = 1'b1;
    cyc(6);
    regs();
    wr(2'h2, 8'h00);
    regs();
    for (int k = 0; k < 14; k++) begin
      r = xs();
      wp_n = r[9] | r[10];
      busy_i = r[11];
      erase_paused_i = r[12];
      program_paused_i = r[13];
      cyc(6);
      if (r[14]) begin
        latch_set_i = 1'b1;
        cyc(1);
        latch_set_i = 1'b0;
        lat = 1'b1;
      end
      if (r[15] && r[3]) begin
        latch_clr_i = 1'b1;
        cyc(1);
        latch_clr_i = 1'b0;
        lat = 1'b0;
      end
      // guard high only at the end, it locks all later writes
      wr(r[1:0], r[23:16] & ((k < 13) ? 8'hFE : 8'hFF));
      regs();
      rd(k % 3);
    end
    busy_i = 1'b1;
    cyc(4);
    fork
      h_u.frame(8'h05, 64, rx, oe);
      begin
        cyc(20);
        busy_i = 1'b0;
      end
    join
    chk(rx[63:56], ex(0) | 8'h01);
    chk(rx[7:0], ex(0));
    h_u.frame(8'h35, 3, rx, oe);
    b = ex(1);
    chk(rx[7:0], {5'h00, b[7:5]});
    h_u.frame(8'hA5, 8, rx, oe);
    chk({7'h00, oe}, 8'h00);
    // reset in mid-run must bring back the defaults and unlock guards
    rst_n = 1'b0;
    cyc(3);
    rst_n = 1'b1;
    e1 = 8'h00;
    e2 = 8'h00;
    e3 = 8'h60;
    lat = 1'b0;
    cyc(6);
    regs();
    rd(2);
    results();
  end
endmodule

//--- design/sfsr_out_stage.sv
`timescale 1ns/1ps
module sfsr_out_stage (
  input wire logic sclk,
  input wire logic link_clr,
  input wire logic active,
  input wire logic bit_in,
  output logic so_o,
  output logic so_oe_n
);

  sfsr_pkg::sfsr_out_s q;
  sfsr_pkg::sfsr_out_s d;

  always_comb begin
    d.so = bit_in;
    d.oe_n = ~active;
  end

  // falling-edge launch; clear floats the pin with no clock edge
  always_ff @(negedge sclk or posedge link_clr) begin
    if (link_clr) begin
      q <= '{so: 1'b0, oe_n: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign so_o = q.so;
  assign so_oe_n = q.oe_n;

endmodule

//--- design/sfsr_pkg.sv
package sfsr_pkg;

  typedef enum logic [1:0] {
    SFSR_OPCODE = 2'b00,
    SFSR_SEND = 2'b01,
    SFSR_IGNORE = 2'b10
  } sfsr_mode_e;

  typedef enum logic [1:0] {
    SFSR_SEL_ONE = 2'b00,
    SFSR_SEL_TWO = 2'b01,
    SFSR_SEL_THREE = 2'b10
  } sfsr_sel_e;

  typedef struct packed {
    logic [7:0] sr1;
    logic [7:0] sr2;
    logic [7:0] sr3;
    logic [2:0] wp_sync;
    logic wp_lvl;
    logic [2:0] cs_sync;
    logic cs_lvl;
    logic [2:0] ack_sync;
    logic ack_lvl;
    logic req;
    logic [23:0] snap;
  } sfsr_core_s;

  typedef struct packed {
    sfsr_mode_e mode;
    logic [2:0] cnt;
    logic [7:0] opc;
    sfsr_sel_e sel;
    logic [2:0] req_sync;
    logic req_lvl;
    logic ack;
    logic [23:0] copy;
    logic [7:0] byte_q;
    logic [2:0] idx;
    logic bit_out;
  } sfsr_link_s;

  typedef struct packed {
    logic so;
    logic oe_n;
  } sfsr_out_s;

  // a change counts only once the last two stages agree
  function automatic logic sfsr_filt(input logic [2:0] s, input logic lvl);
    sfsr_filt = (s[1] == s[2]) ? s[2] : lvl;
  endfunction

  function automatic logic [7:0] sfsr_pick(input logic [23:0] w,
                                           input sfsr_sel_e sel);
    unique case (sel)
      SFSR_SEL_ONE: sfsr_pick = w[23:16];
      SFSR_SEL_TWO: sfsr_pick = w[15:8];
      SFSR_SEL_THREE: sfsr_pick = w[7:0];
      default: sfsr_pick = 8'h00;
    endcase
  endfunction

endpackage

//--- design/sfsr_regs.svh
`ifndef SFSR_REGS_SVH
`define SFSR_REGS_SVH
// Notes on behaviour
// - status reads are answered at any time, even during program or erase.
// - opcode 05h after chip select low streams status_one on serial out.
// - opcode 35h after chip select low streams status_two on serial out.
// - opcode 15h after chip select low streams status_three on serial out.
// - bits go out 7 down to 0, then wrap to 7 while framed.
// - every repeated byte carries the current register contents.
// - chip select high ends the read and floats serial out.
// - chip select may rise at any bit; no full byte is needed.
// - write-status changes only writable bits; read-only bits keep hardware values.
// - status_one bits 7..2: guard low, size select, top/bottom, range b2..b0.
// - status_one bit 1 is write_latch, read-only, 0 by default.
// - status_one bit 0 is busy_flag, read-only, 1 while busy.
// - status_two bit 7 is erase_paused, read-only, default 0.
// - status_two bit 6 is protect_invert, writable, default 0.
// - status_two bits 5..3 lock security pages three..one, writable, default 0.
// - status_two bit 2 is program_paused, read-only, default 0.
// - status_two bit 1 is quad_io_enable, writable, default 0.
// - status_two bit 0 is guard high; with guard low and wp gates writes.
// - status_three bits 6:5 set output strength, default 11 meaning automatic.
// - write_latch clears after write-status, program, erase, page op or disable.

`define SFSR_OP_READ_ONE 8'h05
`define SFSR_OP_READ_TWO 8'h35
`define SFSR_OP_READ_THREE 8'h15

`define SFSR_ONE_RST 8'h00
`define SFSR_TWO_RST 8'h00
`define SFSR_THREE_RST 8'h60

`define SFSR_ONE_WMASK 8'hFC
`define SFSR_TWO_WMASK 8'h7B
`define SFSR_THREE_WMASK 8'hFF
`define SFSR_LOCK_MASK 8'h38

`define SFSR_BIT_BUSY 0
`define SFSR_BIT_LATCH 1
`define SFSR_BIT_GUARD_LOW 7
`define SFSR_BIT_ERASE_PAUSED 7
`define SFSR_BIT_PROG_PAUSED 2
`define SFSR_BIT_QUAD 1
`define SFSR_BIT_GUARD_HIGH 0
`define SFSR_BIT_STRENGTH_MSB 6
`define SFSR_BIT_STRENGTH_LSB 5

`define SFSR_BIT_MSB 3'h7
`define SFSR_BIT_AFTER_MSB 3'h6
`endif

//--- design/sfsr_status_read.sv
`timescale 1ns/1ps
`include "sfsr_regs.svh"
module sfsr_status_read (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si_i,
  input wire logic wp_n,
  output logic so_o,
  output logic so_oe_n,
  input wire logic busy_i,
  input wire logic erase_paused_i,
  input wire logic program_paused_i,
  input wire logic latch_set_i,
  input wire logic latch_clr_i,
  input wire logic wrsr_valid_i,
  input wire logic [1:0] wrsr_sel_i,
  input wire logic [7:0] wrsr_data_i,
  output logic [7:0] status_one_o,
  output logic [7:0] status_two_o,
  output logic [7:0] status_three_o,
  output logic quad_io_enable_o,
  output logic [1:0] output_strength_o
);

  sfsr_pkg::sfsr_core_s core_q;
  sfsr_pkg::sfsr_core_s core_d;
  sfsr_pkg::sfsr_link_s link_q;
  sfsr_pkg::sfsr_link_s link_d;
  logic link_clr;
  logic link_active;

  localparam sfsr_pkg::sfsr_core_s CORE_RST = '{
    sr1: `SFSR_ONE_RST,
    sr2: `SFSR_TWO_RST,
    sr3: `SFSR_THREE_RST,
    wp_sync: 3'h7,
    wp_lvl: 1'b1,
    cs_sync: 3'h7,
    cs_lvl: 1'b1,
    ack_sync: 3'h0,
    ack_lvl: 1'b0,
    req: 1'b0,
    snap: {`SFSR_ONE_RST, `SFSR_TWO_RST, `SFSR_THREE_RST}
  };

  localparam sfsr_pkg::sfsr_link_s LINK_RST = '{
    mode: sfsr_pkg::SFSR_OPCODE,
    cnt: 3'h0,
    opc: 8'h00,
    sel: sfsr_pkg::SFSR_SEL_ONE,
    req_sync: 3'h0,
    req_lvl: 1'b0,
    ack: 1'b0,
    copy: 24'h000000,
    byte_q: 8'h00,
    idx: `SFSR_BIT_MSB,
    bit_out: 1'b0
  };

  // write gate from the two guard bits and the protect pin
  function automatic logic wr_allowed(input logic [7:0] sr1,
                                      input logic [7:0] sr2,
                                      input logic wp_lvl);
    logic gl;
    logic gh;
    gl = sr1[`SFSR_BIT_GUARD_LOW];
    gh = sr2[`SFSR_BIT_GUARD_HIGH];
    wr_allowed = ~gh & (~gl | wp_lvl);
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] data,
                                       input logic [7:0] mask);
    merge = (data & mask) | (old & ~mask);
  endfunction

  // core domain: register file, hardware flags, snapshot handshake
  always_comb begin
    core_d = core_q;
    core_d.wp_sync = {core_q.wp_sync[1:0], wp_n};
    core_d.wp_lvl = sfsr_pkg::sfsr_filt(core_q.wp_sync, core_q.wp_lvl);
    core_d.cs_sync = {core_q.cs_sync[1:0], cs_n};
    core_d.cs_lvl = sfsr_pkg::sfsr_filt(core_q.cs_sync, core_q.cs_lvl);
    core_d.ack_sync = {core_q.ack_sync[1:0], link_q.ack};
    core_d.ack_lvl = sfsr_pkg::sfsr_filt(core_q.ack_sync, core_q.ack_lvl);

    if (wrsr_valid_i && core_q.sr1[`SFSR_BIT_LATCH] &&
        wr_allowed(core_q.sr1, core_q.sr2, core_q.wp_lvl)) begin
      unique case (wrsr_sel_i)
        2'b00: begin
          core_d.sr1 = merge(core_q.sr1, wrsr_data_i,
                             `SFSR_ONE_WMASK);
        end
        2'b01: begin
          // page locks are one-time: a set lock stays set
          core_d.sr2 = merge(core_q.sr2, wrsr_data_i | (core_q.sr2 &
                             `SFSR_LOCK_MASK), `SFSR_TWO_WMASK);
        end
        2'b10: begin
          core_d.sr3 = merge(core_q.sr3, wrsr_data_i,
                             `SFSR_THREE_WMASK);
        end
        default: begin
          core_d.sr1 = core_q.sr1;
        end
      endcase
    end

    // read-only bits always follow hardware, after any write
    core_d.sr1[`SFSR_BIT_BUSY] = busy_i;
    core_d.sr2[`SFSR_BIT_ERASE_PAUSED] = erase_paused_i;
    core_d.sr2[`SFSR_BIT_PROG_PAUSED] = program_paused_i;
    if (latch_set_i) begin
      core_d.sr1[`SFSR_BIT_LATCH] = 1'b1;
    end else if (latch_clr_i || wrsr_valid_i) begin
      core_d.sr1[`SFSR_BIT_LATCH] = 1'b0;
    end

    // snapshot only moves while the link side holds no pending copy
    if (core_q.cs_lvl) begin
      core_d.req = 1'b0;
      core_d.snap = {core_q.sr1, core_q.sr2, core_q.sr3};
    end else if (core_q.ack_lvl == core_q.req) begin
      core_d.req = ~core_q.req;
      core_d.snap = {core_q.sr1, core_q.sr2, core_q.sr3};
    end

    if (!rst_n) begin
      core_d = CORE_RST;
    end
  end

  always_ff @(posedge clk) begin
    core_q <= core_d;
  end

  // link domain: chip select high or reset clears it without a clock
  assign link_clr = cs_n | ~rst_n;

  always_comb begin
    link_d = link_q;
    link_d.req_sync = {link_q.req_sync[1:0], core_q.req};
    link_d.req_lvl = sfsr_pkg::sfsr_filt(link_q.req_sync, link_q.req_lvl);
    unique case (link_q.mode)
      sfsr_pkg::SFSR_OPCODE: begin
        link_d.opc = {link_q.opc[6:0], si_i};
        link_d.cnt = link_q.cnt + 3'h1;
        if (link_q.cnt == `SFSR_BIT_MSB) begin
          link_d.mode = sfsr_pkg::SFSR_SEND;
          unique case ({link_q.opc[6:0], si_i})
            `SFSR_OP_READ_ONE: begin
              link_d.sel = sfsr_pkg::SFSR_SEL_ONE;
            end
            `SFSR_OP_READ_TWO: begin
              link_d.sel = sfsr_pkg::SFSR_SEL_TWO;
            end
            `SFSR_OP_READ_THREE: begin
              link_d.sel = sfsr_pkg::SFSR_SEL_THREE;
            end
            default: begin
              link_d.mode = sfsr_pkg::SFSR_IGNORE;
            end
          endcase
          // copy is taken here from the core snapshot, which the core keeps refreshing through req/ack while the frame lasts
          link_d.copy = core_q.snap;
          link_d.byte_q = sfsr_pkg::sfsr_pick(core_q.snap, link_d.sel);
          link_d.bit_out = link_d.byte_q[`SFSR_BIT_MSB];
          link_d.idx = `SFSR_BIT_AFTER_MSB;
        end
      end
      sfsr_pkg::SFSR_SEND: begin
        if (link_q.req_lvl != link_q.ack) begin
          link_d.copy = core_q.snap;
          link_d.ack = link_q.req_lvl;
        end
        if (link_q.idx == `SFSR_BIT_MSB) begin
          link_d.byte_q = sfsr_pkg::sfsr_pick(link_q.copy, link_q.sel);
          link_d.bit_out = link_d.byte_q[`SFSR_BIT_MSB];
        end else begin
          link_d.bit_out = link_q.byte_q[link_q.idx];
        end
        link_d.idx = link_q.idx - 3'h1;
      end
      sfsr_pkg::SFSR_IGNORE: begin
        link_d.mode = sfsr_pkg::SFSR_IGNORE;
      end
      default: begin
        link_d.mode = sfsr_pkg::SFSR_IGNORE;
      end
    endcase
  end

  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      link_q <= LINK_RST;
    end else begin
      link_q <= link_d;
    end
  end

  assign link_active = (link_q.mode == sfsr_pkg::SFSR_SEND);

  sfsr_out_stage u_out (
    .sclk(sclk),
    .link_clr(link_clr),
    .active(link_active),
    .bit_in(link_q.bit_out),
    .so_o(so_o),
    .so_oe_n(so_oe_n)
  );

  assign status_one_o = core_q.sr1;
  assign status_two_o = core_q.sr2;
  assign status_three_o = core_q.sr3;
  assign quad_io_enable_o = core_q.sr2[`SFSR_BIT_QUAD];
  assign output_strength_o =
    core_q.sr3[`SFSR_BIT_STRENGTH_MSB:`SFSR_BIT_STRENGTH_LSB];

endmodule
